// file: rtl/bldc_ctrl_pkg.sv
package bldc_ctrl_pkg;

    // ****************************************
    // Timer and data widths
    // ****************************************
    localparam int CLK_HZ     = 25_000_000;  // Timer clock rate
    localparam int PWM_PERIOD = 1024;        // Timer counts per PWM period
    localparam int CNT_W      = 10;          // PWM counter width
    localparam int DUTY_W     = 11;          // Duty value width
    localparam int ADC_W      = 12;          // ADC sample width
    localparam int VEL_FRAC   = 16;          // Fraction bits of velocity
    localparam int VEL_W      = 40;          // Velocity accumulator width
    localparam int SPD_W      = 24;          // Integer mHz speed width
    localparam int DIST_W     = 32;          // Rotor distance width
    localparam int INTEG_W    = 24;          // Back-EMF integral width
    localparam int SET_W      = 16;          // Width of count settings
    localparam int SECTORS    = 6;           // Commutation states

    // ****************************************
    // Derived open-loop scale factors
    // ****************************************
    // Velocity gain per PWM period for 1 Hz/s, in mHz << VEL_FRAC
    localparam longint ACCEL_SCALE_L =
        (longint'(1000) * (longint'(1) << VEL_FRAC) * PWM_PERIOD) / CLK_HZ;
    localparam logic [VEL_W-1:0] ACCEL_SCALE = VEL_W'(ACCEL_SCALE_L);
    // Distance (mHz times periods) for one sixth of an electrical cycle
    localparam longint STEP_DIST_L =
        (longint'(1000) * CLK_HZ) / (longint'(SECTORS) * PWM_PERIOD);
    localparam logic [DIST_W-1:0] STEP_DIST = DIST_W'(STEP_DIST_L);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(PWM_PERIOD - 1);
    localparam logic [2:0] SECTOR_LAST = 3'(SECTORS - 1);

    // ****************************************
    // Controller states and ADC channels
    // ****************************************
    typedef enum logic [3:0] {
        ST_IDLE   = 4'h1,
        ST_ALIGN  = 4'h2,
        ST_OPEN   = 4'h4,
        ST_CLOSED = 4'h8
    } state_t;

    typedef enum logic [1:0] {
        CH_BACK_EMF_VOLTAGE   = 2'h0,
        CH_SUPPLY = 2'h1,
        CH_CMD    = 2'h2
    } chan_t;

endpackage

// file: rtl/sensorless_bldc_startup_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Alignment drives the chosen align sector; open loop starts from it.
// - Alignment holds the phases energised for the programmed hold periods.
// - Open loop raises velocity by the acceleration rate and distance by the speed.
// - At each open-loop step compare velocity with handover speed.
// - Open loop loads velocity from the initial setting; zero allowed.
// - Closed loop sums back-EMF samples, commutates at the integral limit.
// - Only samples beyond half supply are summed.
// - Duty changes only after ramp-delay PWM periods have elapsed.
// - Each ramp tick moves duty by the ramp step toward target.
// - After closed-loop commutation ignore back-EMF for blank periods.
// - Back-EMF sample is triggered a set count before PWM edge.
// - A command above maximum duty clamps target to maximum.
// - Once running, a command below minimum-off sets target to zero.
// - Start only after the command exceeds the minimum-on setting.
// - Open loop uses the fixed start-up duty, ignoring the command.
// - Sample trigger from PWM timer; control steps on each period event.
// - Each state drives one high and one low FET, third floats.
// - During blanking the ADC samples supply and command instead.
module sensorless_bldc_startup_ctrl
    import bldc_ctrl_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              resetn_in,
    input  wire logic [2:0]        align_sector_in,
    input  wire logic [SET_W-1:0]  align_hold_in,
    input  wire logic [SET_W-1:0]  open_loop_speed_increment_in,
    input  wire logic [SPD_W-1:0]  closed_loop_handover_speed_in,
    input  wire logic [SPD_W-1:0]  open_loop_initial_speed_in,
    input  wire logic [INTEG_W-1:0] integral_commutate_limit_in,
    input  wire logic [SET_W-1:0]  ramp_delay_in,
    input  wire logic [DUTY_W-1:0] ramp_step_in,
    input  wire logic [SET_W-1:0]  blank_periods_in,
    input  wire logic [CNT_W-1:0]  sample_lead_in,
    input  wire logic [DUTY_W-1:0] max_duty_in,
    input  wire logic [DUTY_W-1:0] min_off_duty_in,
    input  wire logic [DUTY_W-1:0] min_on_duty_in,
    input  wire logic [DUTY_W-1:0] startup_duty_in,
    input  wire logic              adc_valid_in,
    input  wire logic [ADC_W-1:0]  adc_data_in,
    output logic [2:0]             high_gate_out,
    output logic [2:0]             low_gate_out,
    output logic                   adc_trigger_out,
    output logic [1:0]             adc_channel_out,
    output logic [1:0]             float_phase_out,
    output logic [3:0]             state_out,
    output logic [2:0]             sector_out,
    output logic [DUTY_W-1:0]      duty_out,
    output logic                   commutate_out
);

    // ****************************************
    // Helper functions
    // ****************************************
    // High-side and low-side enables {hs, ls} per sector
    function automatic logic [5:0] sector_drive(input logic [2:0] s);
        unique case (s)
            3'h0:    sector_drive = {3'h1, 3'h2};
            3'h1:    sector_drive = {3'h1, 3'h4};
            3'h2:    sector_drive = {3'h2, 3'h4};
            3'h3:    sector_drive = {3'h2, 3'h1};
            3'h4:    sector_drive = {3'h4, 3'h1};
            3'h5:    sector_drive = {3'h4, 3'h2};
            default: sector_drive = 6'h00;
        endcase
    endfunction

    // Index of the floating phase per sector
    function automatic logic [1:0] float_of(input logic [2:0] s);
        unique case (s)
            3'h0, 3'h3: float_of = 2'h2;
            3'h1, 3'h4: float_of = 2'h1;
            default:    float_of = 2'h0;
        endcase
    endfunction

    function automatic logic [2:0] next_sector(input logic [2:0] s);
        next_sector = (s >= SECTOR_LAST) ? 3'h0 : s + 3'h1;
    endfunction

    // ****************************************
    // State
    // ****************************************
    state_t              state_q, state_d;
    chan_t               chan_q, chan_d;
    logic [CNT_W-1:0]    cnt_q, cnt_d;
    logic [DUTY_W-1:0]   duty_q, duty_d;
    logic [DUTY_W-1:0]   target_q, target_d;
    logic [2:0]          sector_q, sector_d;
    logic [SET_W-1:0]    hold_q, hold_d;
    logic [SET_W-1:0]    ramp_q, ramp_d;
    logic [SET_W-1:0]    blank_q, blank_d;
    logic [VEL_W-1:0]    vel_q, vel_d;
    logic [DIST_W-1:0]   dist_q, dist_d;
    logic [INTEG_W-1:0]  integ_q, integ_d;
    logic [ADC_W-1:0]    supply_q, supply_d;
    logic                alt_q, alt_d;
    logic                comm_q, comm_d;
    logic                trig_q, trig_d;
    logic [2:0]          hi_q, hi_d;
    logic [2:0]          lo_q, lo_d;
    logic                period_evt;
    logic [SPD_W-1:0]    speed;
    logic [ADC_W-1:0]    half_supply;
    logic [ADC_W-1:0]    excess;
    logic                beyond_half;
    logic [INTEG_W-1:0]  integ_sum;
    logic [CNT_W-1:0]    trig_point;
    logic                running;

    // Period event and derived values
    assign period_evt  = (cnt_q == CNT_LAST);
    assign speed       = vel_q[VEL_FRAC +: SPD_W];
    assign half_supply = supply_q >> 1;
    assign running     = (state_q != ST_IDLE);
    // Rising back-EMF on odd sectors, falling on even sectors
    assign beyond_half = sector_q[0] ? (adc_data_in > half_supply)
                                     : (adc_data_in < half_supply);
    assign excess      = sector_q[0] ? adc_data_in - half_supply
                                     : half_supply - adc_data_in;
    assign integ_sum   = integ_q + INTEG_W'(excess);
    assign trig_point  = (duty_q > DUTY_W'(sample_lead_in))
                         ? CNT_W'(duty_q - DUTY_W'(sample_lead_in))
                         : '0;

    // ****************************************
    // PWM timer, sample trigger and gates
    // ****************************************
    always_comb begin
        logic [5:0] drv;
        drv   = sector_drive(sector_q);
        cnt_d = period_evt ? '0 : cnt_q + CNT_W'(1);
        trig_d = running && (cnt_q == trig_point);
        if (running) begin
            // One high side pulsed, one low side on, third floats
            hi_d = (DUTY_W'(cnt_q) < duty_q) ? drv[5:3] : 3'h0;
            lo_d = drv[2:0];
        end else begin
            hi_d = 3'h0;
            lo_d = 3'h0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            cnt_q  <= '0;
            trig_q <= 1'b0;
            hi_q   <= 3'h0;
            lo_q   <= 3'h0;
        end else begin
            cnt_q  <= cnt_d;
            trig_q <= trig_d;
            hi_q   <= hi_d;
            lo_q   <= lo_d;
        end
    end

    // ****************************************
    // Control sequencer
    // ****************************************
    always_comb begin
        state_d  = state_q;
        chan_d   = chan_q;
        duty_d   = duty_q;
        target_d = target_q;
        sector_d = sector_q;
        hold_d   = hold_q;
        ramp_d   = ramp_q;
        blank_d  = blank_q;
        vel_d    = vel_q;
        dist_d   = dist_q;
        integ_d  = integ_q;
        supply_d = supply_q;
        alt_d    = alt_q;
        comm_d   = 1'b0;

        // Supply and command samples
        if (adc_valid_in && chan_q == CH_SUPPLY) begin
            supply_d = adc_data_in;
        end
        if (adc_valid_in && chan_q == CH_CMD) begin
            if (adc_data_in > ADC_W'(max_duty_in)) begin
                target_d = max_duty_in;
            end else if (running
                         && adc_data_in < ADC_W'(min_off_duty_in)) begin
                target_d = '0;
            end else begin
                target_d = DUTY_W'(adc_data_in);
            end
        end

        unique case (state_q)
            ST_IDLE: begin
                duty_d = '0;
                if (adc_valid_in && chan_q == CH_CMD
                    && adc_data_in > ADC_W'(min_on_duty_in)) begin
                    state_d  = ST_ALIGN;
                    sector_d = align_sector_in;
                    duty_d   = startup_duty_in;
                    hold_d   = '0;
                end
            end
            ST_ALIGN: begin
                duty_d = startup_duty_in;
                if (period_evt) begin
                    hold_d = hold_q + SET_W'(1);
                    if (hold_q + SET_W'(1) >= align_hold_in) begin
                        state_d = ST_OPEN;
                        vel_d   = VEL_W'(open_loop_initial_speed_in)
                                  << VEL_FRAC;
                        dist_d  = '0;
                    end
                end
            end
            ST_OPEN: begin
                duty_d = startup_duty_in;
                if (period_evt) begin
                    vel_d  = vel_q + VEL_W'(open_loop_speed_increment_in)
                                     * ACCEL_SCALE;
                    dist_d = dist_q + DIST_W'(speed);
                    if (dist_d >= STEP_DIST) begin
                        dist_d   = dist_d - STEP_DIST;
                        sector_d = next_sector(sector_q);
                        comm_d   = 1'b1;
                        if (speed >= closed_loop_handover_speed_in) begin
                            state_d = ST_CLOSED;
                            integ_d = '0;
                            blank_d = blank_periods_in;
                            ramp_d  = '0;
                            duty_d  = duty_q;
                        end
                    end
                end
            end
            ST_CLOSED: begin
                if (period_evt) begin
                    if (blank_q != '0) begin
                        blank_d = blank_q - SET_W'(1);
                    end
                    ramp_d = ramp_q + SET_W'(1);
                    if (ramp_q + SET_W'(1) >= ramp_delay_in) begin
                        ramp_d = '0;
                        if (target_q > duty_q) begin
                            duty_d = (target_q - duty_q > ramp_step_in)
                                     ? duty_q + ramp_step_in
                                     : target_q;
                        end else if (target_q < duty_q) begin
                            duty_d = (duty_q - target_q > ramp_step_in)
                                     ? duty_q - ramp_step_in
                                     : target_q;
                        end
                    end
                    if (duty_q == '0 && target_q == '0) begin
                        state_d = ST_IDLE;
                    end
                end
                // Integrate floating-phase back-EMF outside blanking
                if (adc_valid_in && chan_q == CH_BACK_EMF_VOLTAGE && blank_q == '0
                    && beyond_half) begin
                    integ_d = integ_sum;
                    if (integ_sum >= integral_commutate_limit_in) begin
                        integ_d  = '0;
                        sector_d = next_sector(sector_q);
                        comm_d   = 1'b1;
                        blank_d  = blank_periods_in;
                    end
                end
            end
        endcase

        // Pick the next ADC channel at each period boundary
        if (period_evt) begin
            if (state_d == ST_CLOSED && blank_d == '0) begin
                chan_d = CH_BACK_EMF_VOLTAGE;
            end else begin
                alt_d  = ~alt_q;
                chan_d = alt_q ? CH_CMD : CH_SUPPLY;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            state_q  <= ST_IDLE;
            chan_q   <= CH_SUPPLY;
            duty_q   <= '0;
            target_q <= '0;
            sector_q <= 3'h0;
            hold_q   <= '0;
            ramp_q   <= '0;
            blank_q  <= '0;
            vel_q    <= '0;
            dist_q   <= '0;
            integ_q  <= '0;
            supply_q <= '0;
            alt_q    <= 1'b0;
            comm_q   <= 1'b0;
        end else begin
            state_q  <= state_d;
            chan_q   <= chan_d;
            duty_q   <= duty_d;
            target_q <= target_d;
            sector_q <= sector_d;
            hold_q   <= hold_d;
            ramp_q   <= ramp_d;
            blank_q  <= blank_d;
            vel_q    <= vel_d;
            dist_q   <= dist_d;
            integ_q  <= integ_d;
            supply_q <= supply_d;
            alt_q    <= alt_d;
            comm_q   <= comm_d;
        end
    end

    // Outputs
    assign high_gate_out   = hi_q;
    assign low_gate_out    = lo_q;
    assign adc_trigger_out = trig_q;
    assign adc_channel_out = chan_q;
    assign float_phase_out = float_of(sector_q);
    assign state_out       = state_q;
    assign sector_out      = sector_q;
    assign duty_out        = duty_q;
    assign commutate_out   = comm_q;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    property p_align_sector;
        state_q == ST_ALIGN && $past(state_q) == ST_IDLE
            |-> sector_q == $past(align_sector_in);
    endproperty
    a_align_sector: assert property (p_align_sector)
        else $error("align sector not applied");

    property p_align_hold;
        state_q == ST_OPEN && $past(state_q) == ST_ALIGN
            |-> $past(hold_q) + SET_W'(1) >= $past(align_hold_in);
    endproperty
    a_align_hold: assert property (p_align_hold)
        else $error("alignment left early");

    property p_init_speed;
        state_q == ST_OPEN && $past(state_q) == ST_ALIGN
            |-> speed == $past(open_loop_initial_speed_in);
    endproperty
    a_init_speed: assert property (p_init_speed)
        else $error("open loop speed not loaded");

    property p_handover;
        state_q == ST_CLOSED && $past(state_q) == ST_OPEN
            |-> comm_q && $past(speed) + $past(open_loop_speed_increment_in)
                >= $past(closed_loop_handover_speed_in);
    endproperty
    a_handover: assert property (p_handover)
        else $error("handover without step or speed");

    property p_startup_duty;
        state_q == ST_OPEN && $past(state_q) == ST_OPEN
            |-> duty_q == $past(startup_duty_in);
    endproperty
    a_startup_duty: assert property (p_startup_duty)
        else $error("open loop duty not start-up duty");

    property p_blank_load;
        comm_q && state_q == ST_CLOSED && $past(state_q) == ST_CLOSED
            |-> blank_q == $past(blank_periods_in) && integ_q == '0;
    endproperty
    a_blank_load: assert property (p_blank_load)
        else $error("blanking or integral not reset");

    property p_max_clamp;
        adc_valid_in && chan_q == CH_CMD |=> target_q <= $past(max_duty_in);
    endproperty
    a_max_clamp: assert property (p_max_clamp)
        else $error("target above maximum duty");

    property p_min_on;
        state_q == ST_ALIGN && $past(state_q) == ST_IDLE
            |-> $past(adc_data_in) > ADC_W'($past(min_on_duty_in));
    endproperty
    a_min_on: assert property (p_min_on)
        else $error("started below minimum-on");

    property p_ramp_step;
        state_q == ST_CLOSED && $past(state_q) == ST_CLOSED
            && duty_q != $past(duty_q)
            |-> $past(period_evt) && (duty_q > $past(duty_q)
                ? duty_q - $past(duty_q) : $past(duty_q) - duty_q)
                <= $past(ramp_step_in);
    endproperty
    a_ramp_step: assert property (p_ramp_step)
        else $error("duty moved by more than ramp step");

    c_open: cover property (state_q == ST_OPEN ##1 state_q == ST_OPEN);
    c_closed: cover property ($rose(state_q == ST_CLOSED));
    c_closed_comm: cover property (state_q == ST_CLOSED && comm_q);
    c_stop: cover property ($past(state_q) == ST_CLOSED
                            && state_q == ST_IDLE);

endmodule

`default_nettype wire

// file: verif/bldc_motor_adc_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// ADC and motor stand-in
// ****************************************
module bldc_motor_adc_model
    import bldc_ctrl_pkg::*;
(
    input  wire logic             clk_in,
    input  wire logic             resetn_in,
    input  wire logic             adc_trigger_in,
    input  wire logic [1:0]       adc_channel_in,
    input  wire logic [2:0]       sector_in,
    input  wire logic [ADC_W-1:0] cmd_level_in,
    input  wire logic [ADC_W-1:0] swing_in,
    output logic                  adc_valid_out,
    output logic [ADC_W-1:0]      adc_data_out
);
    localparam logic [ADC_W-1:0] SUPPLY = 12'h800;
    localparam logic [ADC_W-1:0] HALF   = 12'h400;
    int pend;
    int quiet;
    logic [ADC_W-1:0] back_emf_voltage;

    // Odd sectors rise above half supply, even ones fall below
    assign back_emf_voltage = sector_in[0] ? HALF + swing_in : HALF - swing_in;

    initial begin
        adc_valid_out = 1'b0;
        adc_data_out  = 12'h000;
    end

    // Answer a trigger after 4 cycles, else one result a period
    always @(negedge clk_in) begin
        adc_valid_out <= 1'b0;
        adc_data_out  <= ~adc_data_out; // No stale value between results
        if (!resetn_in) begin
            pend  = 0;
            quiet = 0;
        end else if (pend == 1 || quiet >= 1023) begin
            adc_valid_out <= 1'b1;
            pend  = 0;
            quiet = 0;
            case (adc_channel_in)
                2'h1:    adc_data_out <= SUPPLY;
                2'h2:    adc_data_out <= cmd_level_in;
                default: adc_data_out <= back_emf_voltage;
            endcase
        end else begin
            pend  = (pend > 0) ? pend - 1 : 0;
            quiet = quiet + 1;
            if (adc_trigger_in) pend = 4;
        end
    end
endmodule
`default_nettype wire

// file: verif/tb_sensorless_bldc_startup_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sensorless_bldc_startup_ctrl;
    import bldc_ctrl_pkg::*;
    localparam int P = PWM_PERIOD;
    logic              clk_in, resetn_in, adc_valid, trig, comm;
    logic [2:0]        align_sector, sector, hi_g, lo_g;
    logic [SET_W-1:0]  align_hold, accel, ramp_delay, blank;
    logic [SPD_W-1:0]  handover, init_speed;
    logic [INTEG_W-1:0] limit;
    logic [DUTY_W-1:0] ramp_step, max_duty, min_off, min_on, startup;
    logic [DUTY_W-1:0] duty, last;
    logic [CNT_W-1:0]  lead;
    logic [ADC_W-1:0]  adc_data, cmd, swing;
    logic [1:0]        chan, flt;
    logic [3:0]        state;
    int                err_count, cmp_count, cyc, t0, d, n;
    logic [2:0]        s;

    // ****************************************
    // Clock, design and far side
    // ****************************************
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    always @(posedge clk_in) cyc <= cyc + 1;

    sensorless_bldc_startup_ctrl u_dut (
        .clk_in(clk_in), .resetn_in(resetn_in),
        .align_sector_in(align_sector), .align_hold_in(align_hold),
        .open_loop_speed_increment_in(accel),
        .closed_loop_handover_speed_in(handover),
        .open_loop_initial_speed_in(init_speed),
        .integral_commutate_limit_in(limit), .ramp_delay_in(ramp_delay),
        .ramp_step_in(ramp_step), .blank_periods_in(blank),
        .sample_lead_in(lead), .max_duty_in(max_duty),
        .min_off_duty_in(min_off), .min_on_duty_in(min_on),
        .startup_duty_in(startup), .adc_valid_in(adc_valid),
        .adc_data_in(adc_data), .high_gate_out(hi_g), .low_gate_out(lo_g),
        .adc_trigger_out(trig), .adc_channel_out(chan),
        .float_phase_out(flt), .state_out(state), .sector_out(sector),
        .duty_out(duty), .commutate_out(comm));

    bldc_motor_adc_model u_model (
        .clk_in(clk_in), .resetn_in(resetn_in), .adc_trigger_in(trig),
        .adc_channel_in(chan), .sector_in(sector), .cmd_level_in(cmd),
        .swing_in(swing), .adc_valid_out(adc_valid),
        .adc_data_out(adc_data));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input string nm, input logic [39:0] seen,
                         input logic [39:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    function automatic logic hit(input int k);
        case (k)
            0:       hit = (state === 4'h2);
            1:       hit = (state === 4'h4);
            2:       hit = (comm === 1'b1);
            3:       hit = (duty !== last);
            4:       hit = (state === 4'h1);
            default: hit = (duty === 11'h3e8);
        endcase
    endfunction

    task automatic wait_for(input int k, input int periods);
        int i;
        for (i = 0; i < periods * P; i++) begin
            @(negedge clk_in);
            if (hit(k)) break;
        end
        check("wait event", 40'(hit(k)), 40'h1);
    endtask

    task automatic stop_test();
        $display("Checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        repeat (96 * P) @(posedge clk_in);
        err_count++;
        $display("Error watchdog expected end seen timeout");
        stop_test();
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        {err_count, cmp_count} = '0;
        resetn_in = 1'b0;
        align_sector = 3'h1; align_hold = 16'h0003; accel = 16'h03e8;
        handover = 24'h07a120; init_speed = 24'h0f4240;
        limit = 24'h0005d0; ramp_delay = 16'h0002; ramp_step = 11'h07d;
        blank = 16'h0002; lead = 10'h019; max_duty = 11'h3e8;
        min_off = 11'h0fa; min_on = 11'h104; startup = 11'h0fa;
        cmd = 12'h104; swing = 12'h12c;
        repeat (12) @(negedge clk_in);
        check("reset state", state, 4'h1);
        check("reset outs", {sector, duty, chan, hi_g, lo_g}, 22'h000040);
        resetn_in = 1'b1;
        $display("Test reset done");
        repeat (3 * P) @(negedge clk_in);
        check("state at min on", state, 4'h1);
        cmd = 12'h3ff;
        wait_for(0, 3);
        t0 = cyc;
        check("align sector", sector, 3'h1);
        check("align duty", duty, 11'h0fa);
        check("align float", flt, 2'h1);
        @(negedge clk_in); // Gates follow the state one edge later
        check("align low gate", lo_g, 3'h4);
        wait_for(1, 5);
        d = cyc - t0;
        check("align hold", 40'(d >= 2 * P && d <= 4 * P), 40'h1);
        check("open duty", duty, 11'h0fa);
        wait_for(2, 8);
        check("handover state", state, 4'h8);
        check("first step sector", sector, 3'h2);
        $display("Test start-up done");
        last = duty;
        wait_for(3, 6);
        t0 = cyc;
        check("ramp step", duty, 11'h177);
        last = duty;
        wait_for(3, 4);
        check("ramp spacing", 40'(cyc - t0), 40'(2 * P));
        check("ramp step two", duty, 11'h1f4);
        wait_for(5, 12);
        repeat (P) @(negedge clk_in);
        check("clamped duty", duty, 11'h3e8);
        // Cycles from sample trigger to the high-side falling edge
        @(posedge trig);
        @(negedge clk_in);
        n = 0;
        while (hi_g !== 3'h0 && n < P) begin
            @(negedge clk_in);
            n++;
        end
        check("sample lead", 40'(n), 40'(lead));
        $display("Test ramp done");
        wait_for(2, 20);
        t0 = cyc;
        s = sector;
        wait_for(2, 20);
        d = cyc - t0;
        check("next sector", sector, (s == 3'h5) ? 3'h0 : s + 3'h1);
        check("step gap", 40'(d >= 5 * P && d <= 16 * P), 40'h1);
        wait_for(2, 20);
        swing = 12'h000;
        n = 0;
        repeat (8 * P) begin
            @(negedge clk_in);
            if (comm === 1'b1) n++;
        end
        check("steps at half", 40'(n), 40'h0);
        $display("Test integration done");
        swing = 12'h12c; // Commutations resume, so the command is read
        cmd = 12'h064;
        wait_for(4, 40);
        check("stop duty", duty, 11'h000);
        $display("Test stop done");
        stop_test();
    end
endmodule
`default_nettype wire
